// [verilog/pbss_pkg.sv]
// shared constants and carrier types of the pipelined burst synchronous memory
package pbss_pkg;
   localparam int ADDR_W = 18;
   localparam int DATA_W = 18;
   localparam int LANES = 2;
   localparam int LANE_W = 9;
   localparam int BURST_W = 2;
   localparam int WBUF_DEPTH = 8;
   localparam logic [BURST_W-1:0] BURST_START = 2'h0;
   localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
   localparam logic [LANES-1:0] MASK_ALL = 2'h3;
   localparam logic [LANES-1:0] MASK_NONE = 2'h0;

   // one-hot cycle state
   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_READ = 3'h2,
      ST_WRITE = 3'h4
   } pbss_state_type;

   // write waiting for the array
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic [LANES-1:0] mask;
   } pbss_wr_type;

   localparam int WR_W = $bits(pbss_wr_type);
endpackage : pbss_pkg

// [verilog/pbss_fifo.sv]
// small valid/ready fifo that holds writes until the array port is free
`timescale 1ns/1ps
module pbss_fifo #(
   parameter int WIDTH = 38,
   parameter int DEPTH = 8
) (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
   localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

   logic [WIDTH-1:0] store [DEPTH];
   logic [PW-1:0] wr_ptr;
   logic [PW-1:0] rd_ptr;
   logic [CW-1:0] count;
   logic push;
   logic pop;

   assign in_ready_o = (count != FULL_COUNT);
   assign out_valid_o = (count != '0);
   assign out_data_o = store[rd_ptr];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   always_ff @(posedge clk_sys_i)
   begin
      if (push)
      begin
         store[wr_ptr] <= in_data_i;
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end
      else
      begin
         if (push)
         begin
            wr_ptr <= (wr_ptr == LAST_PTR) ? '0 : wr_ptr + PW'(1);
         end
         if (pop)
         begin
            rd_ptr <= (rd_ptr == LAST_PTR) ? '0 : rd_ptr + PW'(1);
         end
         if (push && !pop)
         begin
            count <= count + CW'(1);
         end
         else if (pop && !push)
         begin
            count <= count - CW'(1);
         end
      end
   end
endmodule : pbss_fifo

// [verilog/pbss_mem.sv]
// storage array with per-lane write and registered read data
`timescale 1ns/1ps
module pbss_mem #(
   parameter int ADDR_W = 18,
   parameter int LANES = 2,
   parameter int LANE_W = 9
) (
   input wire logic clk_sys_i,
   input wire logic wr_en_i,
   input wire logic [ADDR_W-1:0] wr_addr_i,
   input wire logic [LANES*LANE_W-1:0] wr_data_i,
   input wire logic [LANES-1:0] wr_mask_i,
   input wire logic [ADDR_W-1:0] rd_addr_i,
   output logic [LANES*LANE_W-1:0] rd_data_o
);
   logic [LANES*LANE_W-1:0] array [2**ADDR_W];

   always_ff @(posedge clk_sys_i)
   begin
      for (int i = 0; i < LANES; i++)
      begin
         if (wr_en_i && wr_mask_i[i])
         begin
            array[wr_addr_i][i*LANE_W +: LANE_W] <= wr_data_i[i*LANE_W +: LANE_W];
         end
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      rd_data_o <= array[rd_addr_i];
   end
endmodule : pbss_mem

// [verilog/pbss_top.sv]
// pipelined burst synchronous memory: strobes, burst counter, byte writes, output drive
`timescale 1ns/1ps
module pbss_top (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic [pbss_pkg::ADDR_W-1:0] addr_i,
   input wire logic proc_addr_strobe_n_i,
   input wire logic ctrl_addr_strobe_n_i,
   input wire logic burst_advance_n_i,
   input wire logic global_write_n_i,
   input wire logic byte_write_enable_n_i,
   input wire logic [pbss_pkg::LANES-1:0] byte_select_n_bus_i,
   input wire logic burst_order_select_i,
   input wire logic master_chip_enable_n_i,
   input wire logic chip_enable_hi_i,
   input wire logic chip_enable_lo_n_i,
   input wire logic output_enable_n_i,
   input wire logic [pbss_pkg::DATA_W-1:0] dq_i,
   output logic [pbss_pkg::DATA_W-1:0] dq_o,
   output logic dq_oe_o,
   output logic wbuf_full_o
);
   pbss_pkg::pbss_state_type state;
   pbss_pkg::pbss_state_type next_state;
   logic [pbss_pkg::ADDR_W-1:0] base;
   logic [pbss_pkg::BURST_W-1:0] cnt;
   logic [pbss_pkg::ADDR_W-1:0] next_base;
   logic [pbss_pkg::BURST_W-1:0] next_cnt;
   logic [pbss_pkg::ADDR_W-1:0] cur_addr;
   logic [pbss_pkg::BURST_W-1:0] low_bits;
   logic oe_meta_n;
   logic oe_sync_n;
   logic order_meta;
   logic order_sync;
   logic rd_hold;
   logic ce_all;
   logic ps_req;
   logic ps_start;
   logic cs_req;
   logic cs_start;
   logic desel;
   logic strobes_high;
   logic wr_req;
   logic bw_low;
   logic [pbss_pkg::LANES-1:0] wr_mask;
   logic push_valid;
   logic push_ready;
   pbss_pkg::pbss_wr_type push_entry;
   pbss_pkg::pbss_wr_type pop_entry;
   logic [pbss_pkg::WR_W-1:0] pop_bits;
   logic pop_valid;
   logic drain;

   // output enable and burst order are not tied to the clock
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         oe_meta_n <= 1'b1;
         oe_sync_n <= 1'b1;
         order_meta <= 1'b1;
         order_sync <= 1'b1;
      end
      else
      begin
         oe_meta_n <= output_enable_n_i;
         oe_sync_n <= oe_meta_n;
         order_meta <= burst_order_select_i;
         order_sync <= order_meta;
      end
   end

   always_comb
   begin
      ce_all = !master_chip_enable_n_i && chip_enable_hi_i && !chip_enable_lo_n_i;
      ps_req = !proc_addr_strobe_n_i && !master_chip_enable_n_i;
      ps_start = ps_req && ce_all;
      // a controller strobe only counts with the processor strobe high
      cs_req = !ctrl_addr_strobe_n_i && proc_addr_strobe_n_i;
      cs_start = cs_req && ce_all;
      desel = (ps_req || cs_req) && !ce_all;
      strobes_high = proc_addr_strobe_n_i && ctrl_addr_strobe_n_i;
      if (!global_write_n_i)
      begin
         wr_mask = pbss_pkg::MASK_ALL;
      end
      else if (!byte_write_enable_n_i)
      begin
         wr_mask = ~byte_select_n_bus_i;
      end
      else
      begin
         wr_mask = pbss_pkg::MASK_NONE;
      end
      wr_req = (wr_mask != pbss_pkg::MASK_NONE);
      bw_low = !global_write_n_i || (byte_select_n_bus_i != pbss_pkg::MASK_ALL);
   end

   // burst address: upper bits fixed, low two bits follow the beat count
   always_comb
   begin
      if (order_sync)
      begin
         low_bits = base[pbss_pkg::BURST_W-1:0] ^ cnt;
      end
      else
      begin
         low_bits = base[pbss_pkg::BURST_W-1:0] + cnt;
      end
      cur_addr = {base[pbss_pkg::ADDR_W-1:pbss_pkg::BURST_W], low_bits};
   end

   always_comb
   begin
      next_state = state;
      next_base = base;
      next_cnt = cnt;
      push_valid = 1'b0;
      push_entry.addr = cur_addr;
      push_entry.data = dq_i;
      push_entry.mask = wr_mask;
      case (state)
         pbss_pkg::ST_IDLE, pbss_pkg::ST_READ, pbss_pkg::ST_WRITE:
         begin
            if (ps_start)
            begin
               // write inputs and advance have no say on this edge
               next_base = addr_i;
               next_cnt = pbss_pkg::BURST_START;
               next_state = pbss_pkg::ST_READ;
            end
            else if (cs_start)
            begin
               next_base = addr_i;
               next_cnt = pbss_pkg::BURST_START;
               if (wr_req)
               begin
                  next_state = pbss_pkg::ST_WRITE;
                  push_valid = 1'b1;
                  push_entry.addr = addr_i;
               end
               else
               begin
                  next_state = pbss_pkg::ST_READ;
               end
            end
            else if (desel)
            begin
               next_state = pbss_pkg::ST_IDLE;
            end
            else if (state != pbss_pkg::ST_IDLE)
            begin
               if (wr_req)
               begin
                  next_state = pbss_pkg::ST_WRITE;
                  push_valid = 1'b1;
                  if (!burst_advance_n_i)
                  begin
                     next_cnt = cnt + pbss_pkg::BURST_STEP;
                     push_entry.addr = {base[pbss_pkg::ADDR_W-1:pbss_pkg::BURST_W],
                        order_sync ? (base[pbss_pkg::BURST_W-1:0] ^ next_cnt)
                                   : (base[pbss_pkg::BURST_W-1:0] + next_cnt)};
                  end
               end
               else
               begin
                  next_state = pbss_pkg::ST_READ;
                  if (!burst_advance_n_i && strobes_high)
                  begin
                     next_cnt = cnt + pbss_pkg::BURST_STEP;
                  end
               end
            end
         end
         default:
         begin
            next_state = pbss_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         state <= pbss_pkg::ST_IDLE;
         base <= '0;
         cnt <= pbss_pkg::BURST_START;
      end
      else
      begin
         state <= next_state;
         base <= next_base;
         cnt <= next_cnt;
      end
   end

   // drivers follow the read pipeline, held one extra cycle after deselect
   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         rd_hold <= 1'b0;
         dq_oe_o <= 1'b0;
      end
      else
      begin
         rd_hold <= (state == pbss_pkg::ST_READ);
         dq_oe_o <= ((state == pbss_pkg::ST_READ) || rd_hold) && !oe_sync_n && !bw_low;
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (!rst_n_i)
      begin
         wbuf_full_o <= 1'b0;
      end
      else
      begin
         wbuf_full_o <= !push_ready;
      end
   end

   // array port goes to reads first; queued writes drain outside read cycles
   assign drain = pop_valid && (state != pbss_pkg::ST_READ);
   assign pop_entry = pop_bits;

   pbss_fifo #(
      .WIDTH(pbss_pkg::WR_W),
      .DEPTH(pbss_pkg::WBUF_DEPTH)
   ) u_wbuf (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .in_valid_i(push_valid),
      .in_ready_o(push_ready),
      .in_data_i(push_entry),
      .out_valid_o(pop_valid),
      .out_ready_i(state != pbss_pkg::ST_READ),
      .out_data_o(pop_bits)
   );

   pbss_mem #(
      .ADDR_W(pbss_pkg::ADDR_W),
      .LANES(pbss_pkg::LANES),
      .LANE_W(pbss_pkg::LANE_W)
   ) u_mem (
      .clk_sys_i(clk_sys_i),
      .wr_en_i(drain),
      .wr_addr_i(pop_entry.addr),
      .wr_data_i(pop_entry.data),
      .wr_mask_i(pop_entry.mask),
      .rd_addr_i(cur_addr),
      .rd_data_o(dq_o)
   );

   ps_read_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      ps_start |=> (state == pbss_pkg::ST_READ) && (base == $past(addr_i)))
      else $error("processor strobe did not start a read");
   ps_adv_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      ps_start |=> (cnt == pbss_pkg::BURST_START))
      else $error("advance acted on the processor strobe edge");
   rd_step_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (state != pbss_pkg::ST_IDLE && !ps_req && !cs_req && !wr_req
       && !burst_advance_n_i && strobes_high)
      |=> (cnt == $past(cnt) + pbss_pkg::BURST_STEP))
      else $error("read burst did not step");
   ps_nowr_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      ps_start |-> !push_valid)
      else $error("write taken on processor strobe edge");
   bw_off_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      bw_low |=> !dq_oe_o)
      else $error("drivers on after write input low");
   wr_step_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (state != pbss_pkg::ST_IDLE && !ps_req && !cs_req && wr_req && !burst_advance_n_i)
      |=> (cnt == $past(cnt) + pbss_pkg::BURST_STEP) && (state == pbss_pkg::ST_WRITE))
      else $error("write burst did not step");
   dcd_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      ((state == pbss_pkg::ST_READ) && desel && !oe_sync_n && !bw_low)
      ##1 (!oe_sync_n && !bw_low) |=> dq_oe_o ##1 (state == pbss_pkg::ST_READ || !dq_oe_o))
      else $error("double cycle deselect not kept");
   cs_write_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (cs_start && wr_req) |=> (state == pbss_pkg::ST_WRITE) && (base == $past(addr_i)))
      else $error("controller strobe write not taken");
   ce_block_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      (master_chip_enable_n_i && ctrl_addr_strobe_n_i && state == pbss_pkg::ST_IDLE)
      |=> (state == pbss_pkg::ST_IDLE))
      else $error("processor strobe not blocked");
   oe_read_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
      dq_oe_o |-> $past(!oe_sync_n) && ($past(state == pbss_pkg::ST_READ) || $past(rd_hold)))
      else $error("drivers on outside a read");
endmodule : pbss_top

// [verification/pbss_master.sv]
// bus master model driving the memory's synchronous pins and output enable
`timescale 1ns/1ps
module pbss_master (
   input wire logic clk_sys_i,
   output logic [17:0] addr_o,
   output logic proc_addr_strobe_n_o,
   output logic ctrl_addr_strobe_n_o,
   output logic burst_advance_n_o,
   output logic global_write_n_o,
   output logic byte_write_enable_n_o,
   output logic [1:0] byte_select_n_bus_o,
   output logic master_chip_enable_n_o,
   output logic chip_enable_hi_o,
   output logic chip_enable_lo_n_o,
   output logic output_enable_n_o,
   output logic [17:0] dq_o
);
   initial
   begin
      addr_o = 18'h0;
      dq_o = 18'h0;
      output_enable_n_o = 1'b1;
      {proc_addr_strobe_n_o, ctrl_addr_strobe_n_o, burst_advance_n_o} = 3'h7;
      {global_write_n_o, byte_write_enable_n_o, byte_select_n_bus_o} = 4'hF;
      {master_chip_enable_n_o, chip_enable_hi_o, chip_enable_lo_n_o} = 3'h2;
   end

   // one edge: ctl = {proc, ctrl, adv, gw, bwe, sel[1:0]}, en = {master_n, hi, lo_n}
   task automatic cyc(input logic [6:0] ctl, input logic [2:0] en, input logic [17:0] a, d);
      @(posedge clk_sys_i);
      proc_addr_strobe_n_o <= ctl[6] | ~ctl[5];
      {ctrl_addr_strobe_n_o, burst_advance_n_o, global_write_n_o} <= ctl[5:3];
      {byte_write_enable_n_o, byte_select_n_bus_o} <= ctl[2:0];
      {master_chip_enable_n_o, chip_enable_hi_o, chip_enable_lo_n_o} <= en;
      addr_o <= a;
      // data lines hold a value only on write edges, otherwise a toggling pattern
      dq_o <= (ctl[3] & ctl[2]) ? ~dq_o : d;
   endtask : cyc

   // raised before writes; the memory passes it through two flops
   task automatic set_oe(input logic off);
      @(posedge clk_sys_i);
      output_enable_n_o <= off;
      repeat (2) @(posedge clk_sys_i);
   endtask : set_oe
endmodule : pbss_master

// [verification/testbench.sv]
// self-checking bench for the pipelined burst synchronous memory
`timescale 1ns/1ps
module testbench;
   localparam logic [6:0] IDLE = 7'h7F;
   localparam logic [6:0] PS_RD = 7'h3F;
   localparam logic [6:0] DESEL = 7'h5F;
   localparam logic [6:0] CS_GW = 7'h57;
   localparam logic [2:0] EN_ON = 3'h2;
   localparam logic [17:0] PAT = 18'h2A5A5;
   typedef struct packed {
      logic [6:0] ctl;
      logic [17:0] a;
      logic [17:0] d;
      logic [17:0] e;
   } pbss_row_type;
   // one write of each kind and the word a later read must return
   pbss_row_type rows [8] = '{
      '{7'h57, 18'h10, 18'h3FFFF, 18'h3FFFF}, '{7'h5A, 18'h10, 18'h00000, 18'h3FE00},
      '{7'h57, 18'h11, 18'h3FFFF, 18'h3FFFF}, '{7'h59, 18'h11, 18'h00000, 18'h001FF},
      '{7'h57, 18'h12, 18'h2AAAA, 18'h2AAAA}, '{7'h5B, 18'h12, 18'h15555, 18'h2AAAA},
      '{7'h51, 18'h13, 18'h12345, 18'h12345}, '{7'h5C, 18'h13, 18'h00000, 18'h12345}};
   logic [2:0] bad_en [3] = '{3'h6, 3'h0, 3'h3};
   logic clk_sys_i = 1'b0;
   logic rst_n_i;
   logic burst_order_select_i;
   logic proc_addr_strobe_n_i, ctrl_addr_strobe_n_i, burst_advance_n_i, global_write_n_i;
   logic byte_write_enable_n_i, master_chip_enable_n_i, chip_enable_hi_i, chip_enable_lo_n_i;
   logic output_enable_n_i, dq_oe_o, wbuf_full_o;
   logic [1:0] byte_select_n_bus_i;
   logic [17:0] addr_i, dq_i, dq_o;
   int num_errors = 0;
   int total_checks = 0;

   always #5 clk_sys_i = ~clk_sys_i;

   pbss_master bm (.clk_sys_i(clk_sys_i), .addr_o(addr_i), .dq_o(dq_i),
      .proc_addr_strobe_n_o(proc_addr_strobe_n_i), .ctrl_addr_strobe_n_o(ctrl_addr_strobe_n_i),
      .burst_advance_n_o(burst_advance_n_i), .global_write_n_o(global_write_n_i),
      .byte_write_enable_n_o(byte_write_enable_n_i), .byte_select_n_bus_o(byte_select_n_bus_i),
      .master_chip_enable_n_o(master_chip_enable_n_i), .chip_enable_hi_o(chip_enable_hi_i),
      .chip_enable_lo_n_o(chip_enable_lo_n_i), .output_enable_n_o(output_enable_n_i));
   pbss_top dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
      .proc_addr_strobe_n_i(proc_addr_strobe_n_i),
      .ctrl_addr_strobe_n_i(ctrl_addr_strobe_n_i),
      .burst_advance_n_i(burst_advance_n_i), .global_write_n_i(global_write_n_i),
      .byte_write_enable_n_i(byte_write_enable_n_i),
      .byte_select_n_bus_i(byte_select_n_bus_i),
      .burst_order_select_i(burst_order_select_i),
      .master_chip_enable_n_i(master_chip_enable_n_i),
      .chip_enable_hi_i(chip_enable_hi_i), .chip_enable_lo_n_i(chip_enable_lo_n_i),
      .output_enable_n_i(output_enable_n_i), .dq_i(dq_i), .dq_o(dq_o), .dq_oe_o(dq_oe_o),
      .wbuf_full_o(wbuf_full_o));

   task automatic check(input logic [17:0] seen, input logic [17:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // deselect, then idle edges so queued writes reach the array
   task automatic settle;
      bm.cyc(DESEL, 3'h3, 18'h0, 18'h0);
      repeat (12) bm.cyc(IDLE, EN_ON, 18'h0, 18'h0);
   endtask : settle

   task automatic wr(input logic [6:0] ctl, input logic [2:0] en, input logic [17:0] a, d);
      bm.set_oe(1'b1);
      bm.cyc(ctl, en, a, d);
      settle();
   endtask : wr

   task automatic rd(input logic [17:0] a, input logic [17:0] exp);
      bm.set_oe(1'b0);
      bm.cyc(PS_RD, EN_ON, a, 18'h0);
      bm.cyc(IDLE, EN_ON, a, 18'h0);
      @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      check(dq_o, exp);
      check({17'h0, dq_oe_o}, 18'h1);
      settle();
   endtask : rd

   task automatic complete_run;
      $display("checks %0d, mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : complete_run

   initial
   begin
      logic [17:0] a;
      logic [17:0] ea;
      logic [1:0] c;
      rst_n_i <= 1'b0;
      burst_order_select_i <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      @(negedge clk_sys_i);
      check({16'h0, dq_oe_o, wbuf_full_o}, 18'h0);
      $display("reset done");
      for (int i = 0; i < 8; i++)
      begin
         wr(rows[i].ctl, EN_ON, rows[i].a, rows[i].d);
         rd(rows[i].a, rows[i].e);
      end
      check({17'h0, wbuf_full_o}, 18'h0);
      $display("write kinds done");
      // back-to-back preload of one block, then bursts in both orders
      bm.set_oe(1'b1);
      for (int i = 0; i < 4; i++)
         bm.cyc(CS_GW, EN_ON, 18'h20 + 18'(i), (18'h20 + 18'(i)) ^ PAT);
      settle();
      for (int o = 0; o < 2; o++)
      begin
         @(posedge clk_sys_i);
         burst_order_select_i <= o[0];
         bm.set_oe(1'b0);
         a = o[0] ? 18'h21 : 18'h22;
         bm.cyc(7'h2F, EN_ON, a, 18'h0);
         for (int k = 0; k < 5; k++)
         begin
            bm.cyc(7'h6F, EN_ON, a, 18'h0);
            @(negedge clk_sys_i);
            c = k[1:0] - 2'h1;
            ea = {a[17:2], o[0] ? a[1:0] ^ c : a[1:0] + c};
            if (k > 0)
               check(dq_o, ea ^ PAT);
         end
         bm.cyc(DESEL, 3'h3, a, 18'h0);
         for (int k = 0; k < 3; k++)
         begin
            bm.cyc(IDLE, EN_ON, a, 18'h0);
            @(negedge clk_sys_i);
            check({17'h0, dq_oe_o}, {17'h0, k < 2});
         end
         settle();
      end
      $display("bursts done");
      // write inputs on the strobe edge are ignored; the next edge steps, then writes
      bm.set_oe(1'b0);
      bm.cyc(7'h38, EN_ON, 18'h20, 18'h11111);
      bm.cyc(7'h68, EN_ON, 18'h20, 18'h0BEEF);
      bm.cyc(IDLE, EN_ON, 18'h20, 18'h0);
      @(negedge clk_sys_i);
      check({17'h0, dq_oe_o}, 18'h0);
      settle();
      rd(18'h20, 18'h20 ^ PAT);
      rd(18'h21, 18'h0BEEF);
      $display("burst write done");
      for (int k = 0; k < 3; k++)
      begin
         bm.set_oe(1'b0);
         bm.cyc(PS_RD, bad_en[k], 18'h20, 18'h0);
         bm.cyc(IDLE, EN_ON, 18'h20, 18'h0);
         @(posedge clk_sys_i);
         @(negedge clk_sys_i);
         check({17'h0, dq_oe_o}, 18'h0);
         settle();
      end
      // master enable off: processor strobe ignored, controller strobe still deselects
      bm.set_oe(1'b0);
      bm.cyc(PS_RD, EN_ON, 18'h20, 18'h0);
      bm.cyc(PS_RD, 3'h6, 18'h40, 18'h0);
      bm.cyc(DESEL, 3'h6, 18'h40, 18'h0);
      repeat (2) bm.cyc(IDLE, EN_ON, 18'h40, 18'h0);
      @(negedge clk_sys_i);
      check({17'h0, dq_oe_o}, 18'h1);
      bm.cyc(IDLE, EN_ON, 18'h40, 18'h0);
      @(negedge clk_sys_i);
      check({17'h0, dq_oe_o}, 18'h0);
      settle();
      // a controller strobe without every enable loads no address, so nothing is written
      wr(CS_GW, 3'h6, 18'h20, 18'h3C3C3);
      rd(18'h20, 18'h20 ^ PAT);
      $display("enables done");
      // reset in the middle of a read drops the drive
      bm.set_oe(1'b0);
      bm.cyc(PS_RD, EN_ON, 18'h40, 18'h0);
      bm.cyc(IDLE, EN_ON, 18'h40, 18'h0);
      @(posedge clk_sys_i);
      rst_n_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      @(negedge clk_sys_i);
      check({16'h0, dq_oe_o, wbuf_full_o}, 18'h0);
      $display("mid-run reset done");
      complete_run();
   end

   initial
   begin
      repeat (3000) @(posedge clk_sys_i);
      num_errors++;
      $display("watchdog expired");
      complete_run();
   end
endmodule : testbench
